// ### verilog/csc_params.svh
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH
`define CSC_OFF_MAIN_CTRL 12'h000
`define CSC_OFF_TRIM 12'h004
`define CSC_OFF_STATUS 12'h008
`define CSC_BIT_SLOW 0
`define CSC_BIT_CLKOUT 1
`define CSC_RST_MAIN_CTRL 8'h00
`define CSC_RST_TRIM 8'hFF
`define CSC_SLOW_DIV 6'd32
`define CSC_RST_PULSE_NS 20000
`define CSC_CLK_NS 8
`define CSC_RST_PULSE_CYC ((`CSC_RST_PULSE_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS)
`endif

// ### verilog/csc_pkg.sv
// Types shared by the clock control block
`default_nettype none
package csc_pkg;
    typedef enum logic [1:0] {
        CSC_SRC_EXT = 2'b00,
        CSC_SRC_XTAL = 2'b01,
        CSC_SRC_RC = 2'b10
    } csc_src_e;
    typedef enum logic [1:0] {
        CSC_RUN = 2'b00,
        CSC_WAIT = 2'b01,
        CSC_SLOW = 2'b10,
        CSC_SLOW_WAIT = 2'b11
    } csc_mode_e;
    typedef logic [7:0] csc_byte_t;
endpackage
`default_nettype wire

// ### verilog/csc_div_if.sv
// Enable bundle between the clock control top and its divider
`default_nettype none
interface csc_div_if;
    logic slow_sel;
    logic tick;
    logic slow_active;
    modport ctrl (output slow_sel, input tick, input slow_active);
    modport div (input slow_sel, output tick, output slow_active);
endinterface
`default_nettype wire

// ### verilog/csc_slow_div.sv
// Divide-by-32 enable generator with boundary-aligned mode switching
`include "csc_params.svh"
`default_nettype none
module csc_slow_div (
    input wire logic clk_sys,
    input wire logic arst_n,
    csc_div_if.div dif
);
    logic [5:0] cnt_q;
    logic tick_q;
    logic active_q;
    wire wrap = (cnt_q == `CSC_SLOW_DIV - 6'd1);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 6'h00;
        end else if (wrap) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end
    // Mode changes only on a period boundary, so no short enable period
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            active_q <= 1'b0;
        end else if (wrap) begin
            active_q <= dif.slow_sel;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= active_q ? wrap : 1'b1;
        end
    end
    assign dif.tick = tick_q;
    assign dif.slow_active = active_q;
endmodule // csc_slow_div
`default_nettype wire

// ### verilog/csc_clock_ctrl.sv
// Clock select, clock output gate, RC trim and watchdog reset pulse control
//
// Added by the designer: register access over APB and the placing of the registers.
`include "csc_params.svh"
`default_nettype none
module csc_clock_ctrl
    import csc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic multi_osc_en,
    input wire logic [1:0] osc_src_opt,
    input wire logic [1:0] xtal_range_opt,
    input wire logic wait_req,
    input wire logic wake_req,
    input wire logic wdg_underflow,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic clock_output_en,
    output logic clock_output_oe_n,
    output logic [7:0] trim_value,
    output logic [1:0] osc_src_sel,
    output logic [1:0] xtal_range,
    output logic xtal_run,
    output logic [1:0] power_mode,
    output logic reset_out,
    output logic reset_oe_n
);
    csc_div_if dif ();
    csc_byte_t main_ctrl_q;
    csc_byte_t trim_q;
    csc_mode_e mode_q;
    logic [1:0] src_sync0_q, src_sync1_q, rng_sync0_q, rng_sync1_q;
    logic mo_sync0_q, mo_sync1_q, wt_sync0_q, wt_sync1_q, wk_sync0_q, wk_sync1_q;
    logic [15:0] rst_cnt_q;
    logic wdg_prev_q;
    csc_src_e src_d;
    wire acc = psel & penable;
    wire wr = acc & pwrite;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    csc_slow_div u_div (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .dif(dif)
    );
    assign dif.slow_sel = main_ctrl_q[`CSC_BIT_SLOW];

    // Option inputs and the wait and wake pins are synchronised before use; wdg_underflow is edge-detected unsynchronised
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            src_sync0_q <= 2'h0;
            src_sync1_q <= 2'h0;
            rng_sync0_q <= 2'h0;
            rng_sync1_q <= 2'h0;
            mo_sync0_q <= 1'b0;
            mo_sync1_q <= 1'b0;
            wt_sync0_q <= 1'b0;
            wt_sync1_q <= 1'b0;
            wk_sync0_q <= 1'b0;
            wk_sync1_q <= 1'b0;
        end else begin
            src_sync0_q <= osc_src_opt;
            src_sync1_q <= src_sync0_q;
            rng_sync0_q <= xtal_range_opt;
            rng_sync1_q <= rng_sync0_q;
            mo_sync0_q <= multi_osc_en;
            mo_sync1_q <= mo_sync0_q;
            wt_sync0_q <= wait_req;
            wt_sync1_q <= wt_sync0_q;
            wk_sync0_q <= wake_req;
            wk_sync1_q <= wk_sync0_q;
        end
    end

    // APB: zero-wait access, upper six control bits held at zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            main_ctrl_q <= `CSC_RST_MAIN_CTRL;
        end else if (wr && hit(paddr, `CSC_OFF_MAIN_CTRL)) begin
            main_ctrl_q <= {6'h00, pwdata[1:0]};
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trim_q <= `CSC_RST_TRIM;
        end else if (wr && hit(paddr, `CSC_OFF_TRIM)) begin
            trim_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                if (hit(paddr, `CSC_OFF_MAIN_CTRL)) begin
                    prdata <= {24'h000000, main_ctrl_q};
                end else if (hit(paddr, `CSC_OFF_TRIM)) begin
                    prdata <= {24'h000000, trim_q};
                end else if (hit(paddr, `CSC_OFF_STATUS)) begin
                    prdata <= {27'h0000000, src_d, mode_q, dif.slow_active};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // Source choice: external clock pin unless multi-oscillator in use
    always_comb begin
        if (!mo_sync1_q) begin
            src_d = CSC_SRC_EXT;
        end else if (src_sync1_q == 2'b10) begin
            src_d = CSC_SRC_RC;
        end else begin
            src_d = CSC_SRC_XTAL;
        end
    end

    // Power mode tracking, wait in slow mode gives slow-wait
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= CSC_RUN;
        end else begin
            unique case (mode_q)
                CSC_RUN: begin
                    if (wt_sync1_q) mode_q <= CSC_WAIT;
                    else if (dif.slow_active) mode_q <= CSC_SLOW;
                end
                CSC_SLOW: begin
                    if (wt_sync1_q) mode_q <= CSC_SLOW_WAIT;
                    else if (!dif.slow_active) mode_q <= CSC_RUN;
                end
                CSC_WAIT: begin
                    if (wk_sync1_q) mode_q <= dif.slow_active ? CSC_SLOW : CSC_RUN;
                end
                CSC_SLOW_WAIT: begin
                    if (wk_sync1_q) mode_q <= dif.slow_active ? CSC_SLOW : CSC_RUN;
                end
            endcase
        end
    end

    // Watchdog underflow stretches a low reset pulse
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt_q <= 16'h0000;
            wdg_prev_q <= 1'b0;
        end else begin
            wdg_prev_q <= wdg_underflow;
            if (wdg_underflow && !wdg_prev_q) begin
                rst_cnt_q <= 16'(`CSC_RST_PULSE_CYC);
            end else if (rst_cnt_q != 16'h0000) begin
                rst_cnt_q <= rst_cnt_q - 16'h0001;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            clock_output_en <= 1'b0;
            clock_output_oe_n <= 1'b1;
            trim_value <= `CSC_RST_TRIM;
            osc_src_sel <= 2'b00;
            xtal_range <= 2'b00;
            xtal_run <= 1'b1;
            power_mode <= 2'b00;
            reset_out <= 1'b1;
            reset_oe_n <= 1'b1;
        end else begin
            cpu_clk_en <= dif.tick & ~mode_q[0];
            periph_clk_en <= dif.tick;
            clock_output_en <= main_ctrl_q[`CSC_BIT_CLKOUT];
            clock_output_oe_n <= ~main_ctrl_q[`CSC_BIT_CLKOUT];
            trim_value <= trim_q;
            osc_src_sel <= src_d;
            xtal_range <= rng_sync1_q;
            xtal_run <= 1'b1;
            power_mode <= mode_q;
            reset_out <= 1'b0;
            reset_oe_n <= (rst_cnt_q == 16'h0000);
        end
    end
endmodule // csc_clock_ctrl
`default_nettype wire

// ### verification/csc_osc_model.sv
// Oscillator source model: strapping and option settings
`default_nettype none
module csc_osc_model (
    input wire logic [1:0] cfg,
    input wire logic [1:0] rng,
    output logic multi_osc_en,
    output logic [1:0] osc_src_opt,
    output logic [1:0] xtal_range_opt
);
    timeunit 1ns;
    timeprecision 1ps;
    assign multi_osc_en = (cfg != 2'h0);
    assign osc_src_opt = (cfg == 2'h2) ? 2'h2 : 2'h1;
    assign xtal_range_opt = rng;
endmodule // csc_osc_model
`default_nettype wire

// ### verification/csc_clock_ctrl_sva.sv
// Port checker of the clock control block
`include "csc_params.svh"
`default_nettype none
module csc_clock_ctrl_chk
    import csc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic multi_osc_en,
    input wire logic wdg_underflow,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic clock_output_en,
    input wire logic clock_output_oe_n,
    input wire logic [1:0] osc_src_sel,
    input wire logic xtal_run,
    input wire logic [1:0] power_mode,
    input wire logic reset_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    logic [1:0] up_q;
    logic [11:0] low_q;
    logic [5:0] gap_q;
    // Cycles since the last peripheral enable pulse
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gap_q <= 6'h00;
        end else if (periph_clk_en) begin
            gap_q <= 6'h00;
        end else if (gap_q != 6'h3F) begin
            gap_q <= gap_q + 6'h01;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) low_q <= 12'h000;
        else low_q <= reset_oe_n ? 12'h000 : low_q + 12'h001;
    end
    property p_apb; psel && !penable |=> pready; endproperty
    a_apb: assert property (p_apb) else $error("no ready after setup");
    property p_oe; clock_output_oe_n != clock_output_en; endproperty
    a_oe: assert property (p_oe) else $error("clock pin enable mismatch");
    property p_run; up_q == 2'h3 && power_mode == CSC_RUN && $past(power_mode, 2) == CSC_RUN
        && $past(power_mode) == CSC_RUN |-> cpu_clk_en; endproperty
    a_run: assert property (p_run) else $error("cpu enable gap in run");
    property p_slow; power_mode == CSC_SLOW && periph_clk_en |-> gap_q >= `CSC_SLOW_DIV - 6'd1;
    endproperty
    a_slow: assert property (p_slow) else $error("slow pulse too soon");
    property p_same; power_mode == CSC_SLOW |-> cpu_clk_en == periph_clk_en; endproperty
    a_same: assert property (p_same) else $error("peripheral clock differs");
    property p_swait; power_mode == CSC_SLOW_WAIT |-> !cpu_clk_en; endproperty
    a_swait: assert property (p_swait) else $error("cpu runs in slow wait");
    property p_wdg; $rose(wdg_underflow) |-> ##2 !reset_oe_n; endproperty
    a_wdg: assert property (p_wdg) else $error("reset pin not driven");
    property p_width; $rose(reset_oe_n) |-> low_q >= `CSC_RST_PULSE_CYC; endproperty
    a_width: assert property (p_width) else $error("reset pulse short");
    property p_xtal; xtal_run; endproperty
    a_xtal: assert property (p_xtal) else $error("crystal stopped");
    property p_ext; !multi_osc_en [*6] |-> osc_src_sel == CSC_SRC_EXT; endproperty
    a_ext: assert property (p_ext) else $error("external source not used");
endmodule // csc_clock_ctrl_chk
bind csc_clock_ctrl csc_clock_ctrl_chk u_chk (.clk_sys, .arst_n, .psel, .penable, .pready,
    .multi_osc_en, .wdg_underflow, .cpu_clk_en, .periph_clk_en, .clock_output_en,
    .clock_output_oe_n, .osc_src_sel, .xtal_run, .power_mode, .reset_oe_n);
`default_nettype wire

// ### verification/tb.sv
// Testbench of the clock control block
`include "csc_params.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic wait_req = 0, wake_req = 0, wdg_underflow = 0, pready, pslverr, multi_osc_en;
    logic cpu_clk_en, periph_clk_en, clock_output_en, clock_output_oe_n, xtal_run;
    logic reset_out, reset_oe_n;
    logic [1:0] cfg = 0, rng = 0, osc_src_opt, xtal_range_opt, osc_src_sel, xtal_range, power_mode;
    logic [7:0] trim_value;
    logic [7:0] tv [4] = '{8'h80, 8'hC0, 8'hA0, 8'h00};
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    int mismatches = 0, checks = 0, c, p;
    always #4 clk_sys = ~clk_sys;
    csc_clock_ctrl u_dut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .multi_osc_en, .osc_src_opt, .xtal_range_opt, .wait_req,
        .wake_req, .wdg_underflow, .cpu_clk_en, .periph_clk_en, .clock_output_en,
        .clock_output_oe_n, .trim_value, .osc_src_sel, .xtal_range, .xtal_run, .power_mode,
        .reset_out, .reset_oe_n);
    csc_osc_model u_osc (.cfg, .rng, .multi_osc_en, .osc_src_opt, .xtal_range_opt);
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task win;
        c = 0;
        p = 0;
        repeat (64) begin
            @(posedge clk_sys);
            c += cpu_clk_en;
            p += periph_clk_en;
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100us;
        mismatches++;
        final_report;
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        chk("xtal_run", xtal_run, 1);
        arst_n <= 1;
        apb(0, 12'h000, 0);
        chk("ctrl", rd, 0);
        apb(0, 12'h004, 0);
        chk("trim", rd, 32'hFF);
        chk("oe_n", clock_output_oe_n, 1);
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'h004, tv[i]);
            apb(0, 12'h004, 0);
            chk("trim", rd, tv[i]);
            chk("trim_out", trim_value, tv[i]);
        end
        apb(1, 12'h000, 32'h2);
        apb(0, 12'h000, 0);
        chk("ctrl", rd, 32'h2);
        chk("oe_n", clock_output_oe_n, 0);
        chk("clkout", clock_output_en, 1);
        apb(0, 12'h00C, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        apb(1, 12'h000, 32'h1);
        repeat (40) @(posedge clk_sys);
        win;
        chk("cpu_slow", c, 2);
        chk("per_slow", p, 2);
        apb(0, 12'h008, 0);
        chk("stat", rd[4:0], 5'h05);
        wait_req <= 1;
        repeat (8) @(posedge clk_sys);
        chk("mode", power_mode, 2'h3);
        win;
        chk("cpu_sw", c, 0);
        chk("per_sw", p, 2);
        wait_req <= 0;
        wake_req <= 1;
        repeat (8) @(posedge clk_sys);
        wake_req <= 0;
        chk("mode", power_mode, 2'h2);
        apb(1, 12'h000, 0);
        repeat (40) @(posedge clk_sys);
        win;
        chk("cpu_run", c, 64);
        wait_req <= 1;
        repeat (8) @(posedge clk_sys);
        chk("mode", power_mode, 2'h1);
        win;
        chk("cpu_w", c, 0);
        chk("per_w", p, 64);
        wait_req <= 0;
        wake_req <= 1;
        repeat (8) @(posedge clk_sys);
        wake_req <= 0;
        chk("mode", power_mode, 2'h0);
        for (int i = 0; i < 3; i++) begin
            cfg <= 2'(i);
            rng <= 2'(i);
            repeat (8) @(posedge clk_sys);
            chk("src", osc_src_sel, i);
            chk("range", xtal_range, i);
        end
        wdg_underflow <= 1;
        repeat (3) @(posedge clk_sys);
        chk("rst_pin", reset_oe_n, 0);
        chk("rst_out", reset_out, 0);
        wdg_underflow <= 0;
        c = 0;
        while (reset_oe_n !== 1'b1) begin
            @(posedge clk_sys);
            c++;
        end
        chk("pulse", c + 3 >= `CSC_RST_PULSE_CYC, 1);
        apb(1, 12'h000, 32'h3);
        apb(1, 12'h004, 32'h5A);
        arst_n <= 0;
        repeat (2) @(posedge clk_sys);
        chk("xtal_run", xtal_run, 1);
        chk("oe_n", clock_output_oe_n, 1);
        chk("trim_out", trim_value, 8'hFF);
        arst_n <= 1;
        apb(0, 12'h000, 0);
        chk("ctrl", rd, 0);
        apb(0, 12'h004, 0);
        chk("trim", rd, 32'hFF);
        final_report;
    end
endmodule // tb
`default_nettype wire
